// [logic/cof_ctrl.sv]
// Comparator output control, digital filter and interrupt edge logic.
// Notes on behaviour
// R1: Output control register is zero after reset: low speed, all off.
// R2: Polarity bit 2 passes the result to the pin straight or inverted.
// R3: Pin enable bit 1 drives the result onto the pin, else disabled.
// R4: Interrupt enable bit 0 permits requests; when clear none are raised.
// R5: Software clears operation enable before changing speed bit 7.
// R6: Monitor flag reads 1 when input is above reference, else 0.
// R7: With interrupts enabled, selected result edges raise a request.
// R8: Both-edge 0, polarity-edge 0: request on rising edges only.
// R9: Both-edge 0, polarity-edge 1: request on falling edges only.
// R10: Both-edge 1: request on every rising and falling edge.
// R11: Filter output takes a level after three agreeing samples.
// R12: Filter code 00 bypasses the filter; other codes enable it.
// R13: Edge detector reads filter output when enabled, else raw result.
// R14: Software sets port mode bits for the analog input pins.
// R15: Software clears port bits to route the result to the pin.
// R16: Codes 01, 10, 11 sample at clock, clock/8, clock/32.
// R17: Software waits four sampling clocks before enabling interrupts.
// R18: With clock gate 0, control registers stay reset, writes ignored.
// R19: Software disables interrupts around edge or filter changes.
// R20: Raw result passes a two-stage synchronizer before use.
// R21: Each edge gives a one-cycle pulse; none while operation is off.
// R22: Pin is low while its enable is 0, else the result.
`timescale 1ns/100ps
`default_nettype none
module cof_ctrl (
    input  wire logic              sys_clk_i,         // 200 MHz clock
    input  wire logic              sys_rst_i,         // Async reset, high
    input  wire cof_pkg::cof_addr_t avs_address_i,    // Byte address
    input  wire logic              avs_read_i,        // Read request
    input  wire logic              avs_write_i,       // Write request
    input  wire cof_pkg::cof_data_t avs_writedata_i,  // Write data
    input  wire logic [3:0]        avs_byteenable_i,  // Byte lanes
    output var  cof_pkg::cof_data_t avs_readdata_o,   // Read data
    output var  logic              avs_waitrequest_o, // Slave stall
    input  wire logic              cmp_result_i,      // Async comparator
    output var  logic              cmp_enable_o,      // Operation enable
    output var  logic              cmp_high_speed_o,  // Speed select
    output var  logic              ref_internal_o,    // Internal reference
    output var  logic              result_out_pin_o,  // Result pin level
    output var  logic              result_out_oe_o,   // Result pin enable
    output var  logic              cmp_irq_request_o  // Interrupt pulse
);
    import cof_pkg::*;

    ////////////////////////////////////////////////////////////////////
    logic       wait_r;
    logic       req;
    logic       acc;
    logic       wr;
    cof_byte_t  wbyte;
    cof_byte_t  gate_r;
    cof_byte_t  mode_r;
    cof_byte_t  fir_r;
    cof_byte_t  oc_r;
    cof_byte_t  rd_byte;
    logic       gate_on;
    logic       res_sync;
    logic       res_filt;
    logic       src_level;
    logic       prev_r;
    logic       edge_rise;
    logic       edge_fall;
    logic       edge_hit;
    logic [4:0] pre_r;
    logic       tick;
    cof_fck_t   fck;
    logic       op_en;
    logic       irq_en;
    logic       both_edge_mode;
    logic       edge_polarity_sel;
    logic       out_polarity;
    logic       pin_out_enable;

    assign gate_on           = gate_r[COF_GATE_BIT];
    assign op_en             = mode_r[COF_MODE_EN];
    assign irq_en            = oc_r[COF_OC_IE];
    assign out_polarity      = oc_r[COF_OC_POL];
    assign pin_out_enable    = oc_r[COF_OC_OE];
    assign both_edge_mode    = fir_r[COF_FIR_EDG];
    assign edge_polarity_sel = fir_r[COF_FIR_EPO];
    assign fck = cof_fck_t'({fir_r[COF_FIR_FCKHI], fir_r[COF_FIR_FCKLO]});

    ////////////////////////////////////////////////////////////////////
    // Bus slave: every access stalls exactly one cycle, so waitrequest
    // can come from a flop and read data is ready at the release edge.
    assign req   = avs_read_i | avs_write_i;
    assign acc   = req & ~wait_r;
    assign wr    = avs_write_i & acc & avs_byteenable_i[0];
    assign wbyte = avs_writedata_i[7:0];

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= ~(req & wait_r);
        end
    end

    assign avs_waitrequest_o = wait_r;

    always_comb begin
        rd_byte = 8'h00;
        case (avs_address_i)
            COF_ADDR_GATE: rd_byte = gate_r;
            COF_ADDR_MODE: begin
                rd_byte = mode_r;
                rd_byte[COF_MODE_MON] = res_sync;   // see R6
            end
            COF_ADDR_FIR:  rd_byte = fir_r;
            COF_ADDR_OC:   rd_byte = oc_r;
            default:       rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && wait_r) begin
            avs_readdata_o <= {24'h00_0000, rd_byte};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Clock gate register is always writable
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gate_r <= COF_GATE_RST;
        end else if (wr && avs_address_i == COF_ADDR_GATE) begin
            gate_r <= wbyte & COF_GATE_WMASK;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_r <= COF_MODE_RST;
        end else if (!gate_on) begin
            mode_r <= COF_MODE_RST;                      // see R18
        end else if (wr && avs_address_i == COF_ADDR_MODE) begin
            mode_r <= wbyte & COF_MODE_WMASK;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fir_r <= COF_FIR_RST;
        end else if (!gate_on) begin
            fir_r <= COF_FIR_RST;                        // see R18
        end else if (wr && avs_address_i == COF_ADDR_FIR) begin
            fir_r <= wbyte & COF_FIR_WMASK;
        end
    end

    // Speed bit written freely; the analog side needs op disabled first
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            oc_r <= COF_OC_RST;                          // see R1
        end else if (!gate_on) begin
            oc_r <= COF_OC_RST;                          // see R18
        end else if (wr && avs_address_i == COF_ADDR_OC) begin
            oc_r <= wbyte & COF_OC_WMASK;                // see R5
        end
    end

    assign cmp_enable_o     = mode_r[COF_MODE_EN];
    assign ref_internal_o   = mode_r[COF_MODE_VRF];
    assign cmp_high_speed_o = oc_r[COF_OC_SPEED];

    ////////////////////////////////////////////////////////////////////
    // Result synchronizer and filter
    cof_sync u_sync (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (cmp_result_i),
        .sync_o    (res_sync)                            // see R20
    );

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pre_r <= COF_PRE_RST;
        end else begin
            pre_r <= pre_r + 5'h01;
        end
    end

    always_comb begin
        case (fck)                                       // see R16
            COF_FCK_DIV1:  tick = 1'b1;
            COF_FCK_DIV8:  tick = (pre_r & COF_DIV8_MASK) == COF_DIV8_LAST;
            COF_FCK_DIV32: tick = pre_r == COF_DIV32_LAST;
            default:       tick = 1'b0;
        endcase
    end

    cof_filter u_filter (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .bypass_i  (fck == COF_FCK_OFF),                 // see R12
        .tick_i    (tick),
        .level_i   (res_sync),
        .level_o   (res_filt)
    );

    // see R13
    assign src_level = (fck == COF_FCK_OFF) ? res_sync : res_filt;

    ////////////////////////////////////////////////////////////////////
    // Edge detect and interrupt pulse
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= src_level;
        end
    end

    assign edge_rise = src_level & ~prev_r;
    assign edge_fall = ~src_level & prev_r;

    always_comb begin
        if (both_edge_mode) begin
            edge_hit = edge_rise | edge_fall;            // see R10
        end else if (edge_polarity_sel) begin
            edge_hit = edge_fall;                        // see R9
        end else begin
            edge_hit = edge_rise;                        // see R8
        end
    end

    // Changing edge or filter fields live may fire a stray pulse
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmp_irq_request_o <= 1'b0;
        end else begin
            cmp_irq_request_o <= irq_en & op_en & edge_hit; // see R4 R7 R21
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Result pin uses the unfiltered result for least delay
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            result_out_pin_o <= 1'b0;
            result_out_oe_o  <= 1'b0;
        end else begin
            result_out_pin_o <= pin_out_enable               // see R3 R22
                                & (res_sync ^ out_polarity); // see R2
            result_out_oe_o  <= pin_out_enable;              // see R3
        end
    end

    ////////////////////////////////////////////////////////////////////
    reg_gate_a: assert property (@(posedge sys_clk_i) // see R18
        disable iff (sys_rst_i)
        !gate_on |=> (oc_r == 8'h00) && (fir_r == 8'h00) && !cmp_enable_o)
        else $error("control register kept a value while gate was off");

    pin_pol_a: assert property (@(posedge sys_clk_i) // see R2
        disable iff (sys_rst_i)
        $past(pin_out_enable)
        |-> result_out_pin_o
            == ($past(cmp_result_i, 3) ^ $past(out_polarity)))
        else $error("result pin polarity wrong");

    pin_off_a: assert property (@(posedge sys_clk_i) // see R3
        disable iff (sys_rst_i)
        !pin_out_enable |=> !result_out_pin_o && !result_out_oe_o)
        else $error("result pin active while disabled");

    irq_gate_a: assert property (@(posedge sys_clk_i) // see R4
        disable iff (sys_rst_i)
        cmp_irq_request_o |-> $past(irq_en) && $past(op_en))
        else $error("interrupt raised while disabled");

    rise_only_a: assert property (@(posedge sys_clk_i) // see R8
        disable iff (sys_rst_i)
        cmp_irq_request_o && !$past(both_edge_mode)
        && !$past(edge_polarity_sel)
        |-> $past(src_level) && !$past(src_level, 2))
        else $error("rising mode fired without rising edge");

    fall_only_a: assert property (@(posedge sys_clk_i) // see R9
        disable iff (sys_rst_i)
        cmp_irq_request_o && !$past(both_edge_mode)
        && $past(edge_polarity_sel)
        |-> !$past(src_level) && $past(src_level, 2))
        else $error("falling mode fired without falling edge");

    both_edge_a: assert property (@(posedge sys_clk_i) // see R10 R7
        disable iff (sys_rst_i)
        irq_en && op_en && both_edge_mode && (src_level != prev_r)
        |=> cmp_irq_request_o)
        else $error("edge missed in both-edge mode");

    bypass_a: assert property (@(posedge sys_clk_i) // see R12 R13
        disable iff (sys_rst_i)
        fck == COF_FCK_OFF && $past(fck == COF_FCK_OFF)
        |-> src_level == res_sync && res_filt == $past(res_sync))
        else $error("filter not bypassed for code zero");

    sync_lag_a: assert property (@(posedge sys_clk_i) // see R20 R6
        disable iff (sys_rst_i)
        $rose(res_sync) |-> $past(cmp_result_i, 2))
        else $error("synchronizer latency wrong");

    bus_wait_a: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i)
        req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("slave did not answer in one cycle");

endmodule
`default_nettype wire

// [inc/cof_pkg.sv]
// Constants and types shared by the comparator output filter control.
package cof_pkg;

    typedef logic [21:0] cof_addr_t;
    typedef logic [31:0] cof_data_t;
    typedef logic [7:0]  cof_byte_t;

    // Register indices; byte address is four times the index
    localparam logic [19:0] COF_IDX_GATE = 20'hF00F0;
    localparam logic [19:0] COF_IDX_MODE = 20'hFFF60;
    localparam logic [19:0] COF_IDX_FIR  = 20'hFFF61;
    localparam logic [19:0] COF_IDX_OC   = 20'hFFF62;

    localparam cof_addr_t COF_ADDR_GATE = {COF_IDX_GATE, 2'h0};
    localparam cof_addr_t COF_ADDR_MODE = {COF_IDX_MODE, 2'h0};
    localparam cof_addr_t COF_ADDR_FIR  = {COF_IDX_FIR, 2'h0};
    localparam cof_addr_t COF_ADDR_OC   = {COF_IDX_OC, 2'h0};

    // Values after reset
    localparam cof_byte_t COF_GATE_RST = 8'h00;
    localparam cof_byte_t COF_MODE_RST = 8'h00;
    localparam cof_byte_t COF_FIR_RST  = 8'h00;
    localparam cof_byte_t COF_OC_RST   = 8'h00;

    // Writable bits of each register
    localparam cof_byte_t COF_GATE_WMASK = 8'h20;
    localparam cof_byte_t COF_MODE_WMASK = 8'h05;
    localparam cof_byte_t COF_FIR_WMASK  = 8'h0F;
    localparam cof_byte_t COF_OC_WMASK   = 8'h87;

    // Field positions
    localparam int COF_GATE_BIT  = 5;
    localparam int COF_MODE_MON  = 3;
    localparam int COF_MODE_VRF  = 2;
    localparam int COF_MODE_EN   = 0;
    localparam int COF_FIR_EDG   = 3;
    localparam int COF_FIR_EPO   = 2;
    localparam int COF_FIR_FCKHI = 1;
    localparam int COF_FIR_FCKLO = 0;
    localparam int COF_OC_SPEED  = 7;
    localparam int COF_OC_POL    = 2;
    localparam int COF_OC_OE     = 1;
    localparam int COF_OC_IE     = 0;

    // Filter sampling clock codes
    typedef enum logic [1:0] {
        COF_FCK_OFF   = 2'h0,
        COF_FCK_DIV1  = 2'h1,
        COF_FCK_DIV8  = 2'h2,
        COF_FCK_DIV32 = 2'h3
    } cof_fck_t;

    // Prescaler terminal counts for the divided sampling clocks
    localparam logic [4:0] COF_DIV8_MASK  = 5'h07;
    localparam logic [4:0] COF_DIV8_LAST  = 5'h07;
    localparam logic [4:0] COF_DIV32_LAST = 5'h1F;
    localparam logic [4:0] COF_PRE_RST    = 5'h00;

    // Samples that must agree before the filter output moves
    localparam int COF_FILT_DEPTH = 3;

endpackage

// [logic/cof_sync.sv]
// Two-stage synchronizer for one asynchronous level.
`timescale 1ns/100ps
`default_nettype none
module cof_sync (
    input  wire logic sys_clk_i,   // Peripheral clock
    input  wire logic sys_rst_i,   // Async reset, high
    input  wire logic async_i,     // Level from another domain
    output var  logic sync_o       // Synchronised level
);

    logic meta_r;

    // First stage is read by the second stage only
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_r <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule
`default_nettype wire

// [logic/cof_filter.sv]
// Three-sample majority-free noise filter on the sampling tick.
`timescale 1ns/100ps
`default_nettype none
module cof_filter
    import cof_pkg::*;
(
    input  wire logic sys_clk_i,   // Peripheral clock
    input  wire logic sys_rst_i,   // Async reset, high
    input  wire logic bypass_i,    // Filter off: track input
    input  wire logic tick_i,      // Sampling clock enable
    input  wire logic level_i,     // Synchronised comparator level
    output var  logic level_o      // Filtered level
);

    logic [COF_FILT_DEPTH-1:0] smp_r;
    logic                      agree;

    assign agree = (smp_r == {COF_FILT_DEPTH{smp_r[0]}});

    // While bypassed, preload so a later enable starts settled
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            smp_r   <= '0;
            level_o <= 1'b0;
        end else if (bypass_i) begin
            smp_r   <= {COF_FILT_DEPTH{level_i}};
            level_o <= level_i;
        end else if (tick_i) begin
            smp_r   <= {smp_r[COF_FILT_DEPTH-2:0], level_i};
            if (agree) begin
                level_o <= smp_r[0];   // see R11
            end
        end
    end

    filt_tick_a: assert property (@(posedge sys_clk_i) // see R11
        disable iff (sys_rst_i)
        !$past(bypass_i) && $changed(level_o)
        |-> $past(tick_i) && $past(agree))
        else $error("filter output moved without three agreeing samples");

endmodule
`default_nettype wire

// [sim/cof_cmp_model.sv]
// Behavioural analog comparator that feeds the control block.
`timescale 1ns/100ps
`default_nettype none
module cof_cmp_model #(
    parameter logic [15:0] REF_INT_MV = 16'h032F, // Internal reference, mV
    parameter int          SLOW_DLY   = 4         // Low-speed delay, cycles
) (
    input  wire logic        sys_clk_i,   // Peripheral clock
    input  wire logic        enable_i,    // Operation enable
    input  wire logic        fast_i,      // High-speed mode
    input  wire logic        ref_int_i,   // Internal reference chosen
    input  wire logic [15:0] vin_mv_i,    // Analog input, mV
    input  wire logic [15:0] vref_mv_i,   // Reference pin, mV
    output var  logic        result_o     // Comparison result
);
    logic [7:0]  pipe_r = 8'h00;
    logic        res_r  = 1'b0;
    logic [15:0] ref_mv;

    assign ref_mv   = ref_int_i ? REF_INT_MV : vref_mv_i;
    assign result_o = res_r;

    ////////////////////////////////////////////////////////////////////////
    // Pure delay keeps glitch widths intact for the filter tests
    always_ff @(posedge sys_clk_i) begin
        pipe_r <= {pipe_r[6:0], vin_mv_i > ref_mv};
    end

    // Disabled output is undefined; toggling keeps the block honest
    always_ff @(posedge sys_clk_i) begin
        if (!enable_i) begin
            res_r <= ~res_r;
        end else begin
            res_r <= fast_i ? pipe_r[0] : pipe_r[SLOW_DLY-1];
        end
    end
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the comparator output filter control.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import cof_pkg::*;
    logic        sys_clk_i, sys_rst_i, avs_read_i, avs_write_i;
    logic        avs_waitrequest_o, cmp_result_i, en, hs, refi, pin, oe, irq;
    logic [3:0]  avs_byteenable_i;
    cof_addr_t   avs_address_i;
    cof_data_t   avs_writedata_i, avs_readdata_o, last_rd;
    logic [15:0] vin, vref;
    int          n_mismatch, checks, irq_cnt;

    cof_ctrl uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .cmp_result_i(cmp_result_i),
        .cmp_enable_o(en), .cmp_high_speed_o(hs), .ref_internal_o(refi),
        .result_out_pin_o(pin), .result_out_oe_o(oe),
        .cmp_irq_request_o(irq));

    cof_cmp_model cmp_model (.sys_clk_i(sys_clk_i), .enable_i(en),
        .fast_i(hs), .ref_int_i(refi), .vin_mv_i(vin), .vref_mv_i(vref),
        .result_o(cmp_result_i));

    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        if (irq === 1'b1) irq_cnt++;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    // Request held until waitrequest is sampled low
    task automatic bus(input logic w, input cof_addr_t a, input cof_byte_t d,
                       input logic [3:0] b);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= {24'h000000, d};
        avs_byteenable_i <= b;
        avs_write_i <= w;
        avs_read_i <= ~w;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 100);
        last_rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (n >= 100) n_mismatch++;
    endtask

    task automatic wr(input cof_addr_t a, input cof_byte_t d);
        bus(1'b1, a, d, 4'hF);
    endtask

    task automatic rd_chk(input cof_addr_t a, input cof_byte_t exp);
        bus(1'b0, a, 8'h00, 4'hF);
        check(last_rd, {24'h000000, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_gate();
        check({en, hs, refi, pin, oe, irq, avs_waitrequest_o}, 7'h01);
        rd_chk(COF_ADDR_OC, COF_OC_RST);
        wr(COF_ADDR_OC, 8'h87);
        rd_chk(COF_ADDR_OC, 8'h00);
        wr(COF_ADDR_GATE, 8'h20);
        bus(1'b1, COF_ADDR_OC, 8'h87, 4'h0);
        rd_chk(COF_ADDR_OC, 8'h00);
        rd_chk(22'h000000, 8'h00);
        wr(COF_ADDR_OC, 8'h80);
        rd_chk(COF_ADDR_OC, 8'h80);
        check(hs, 1'b1);
        wr(COF_ADDR_OC, 8'h00);
    endtask

    task automatic t_pin();
        wr(COF_ADDR_MODE, 8'h01);
        vin <= 16'h02BC;
        cyc(12);
        rd_chk(COF_ADDR_MODE, 8'h09);
        check({oe, pin}, 2'h0);
        wr(COF_ADDR_OC, 8'h02);
        cyc(4);
        check({oe, pin}, 2'h3);
        wr(COF_ADDR_OC, 8'h06);
        cyc(4);
        check({oe, pin}, 2'h2);
        vin <= 16'h012C;
        cyc(12);
        check({oe, pin}, 2'h3);
        rd_chk(COF_ADDR_MODE, 8'h01);
        wr(COF_ADDR_OC, 8'h00);
        cyc(4);
        check({oe, pin}, 2'h0);
        wr(COF_ADDR_MODE, 8'h05);
        vin <= 16'h0384;
        vref <= 16'h03E8;
        cyc(12);
        rd_chk(COF_ADDR_MODE, 8'h0D);
        check({en, refi}, 2'h3);
        vin <= 16'h012C;
        vref <= 16'h01F4;
        wr(COF_ADDR_MODE, 8'h01);
    endtask

    task automatic edge_run(input cof_byte_t fir, input cof_byte_t oc,
                            input int up, input int dn);
        wr(COF_ADDR_OC, 8'h00);
        wr(COF_ADDR_FIR, fir);
        cyc(12);
        wr(COF_ADDR_OC, oc);
        irq_cnt = 0;
        vin <= 16'h02BC;
        cyc(16);
        check(irq_cnt, up);
        irq_cnt = 0;
        vin <= 16'h012C;
        cyc(16);
        check(irq_cnt, dn);
    endtask

    task automatic t_bypass();
        wr(COF_ADDR_FIR, 8'h00);
        cyc(12);
        wr(COF_ADDR_OC, 8'h01);
        irq_cnt = 0;
        vin <= 16'h02BC;
        cyc(2);
        vin <= 16'h012C;
        cyc(16);
        check(irq_cnt, 1);
    endtask

    // Glitch spans two samples only, so the filter must hold
    task automatic filt_run(input cof_byte_t code, input int div);
        wr(COF_ADDR_OC, 8'h00);
        wr(COF_ADDR_FIR, code);
        cyc(4 * div + 12);
        wr(COF_ADDR_OC, 8'h01);
        irq_cnt = 0;
        vin <= 16'h02BC;
        cyc(2 * div);
        vin <= 16'h012C;
        cyc(6 * div + 12);
        check(irq_cnt, 0);
        vin <= 16'h02BC;
        cyc(2 * div);
        check(irq_cnt, 0);
        cyc(3 * div + 12);
        check(irq_cnt, 1);
        vin <= 16'h012C;
        cyc(5 * div + 12);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        {n_mismatch, checks, irq_cnt} = '0;
        sys_rst_i = 1'b1;
        {avs_read_i, avs_write_i} = 2'h0;
        avs_byteenable_i = 4'hF;
        avs_address_i = '0;
        avs_writedata_i = '0;
        vin = 16'h012C;
        vref = 16'h01F4;
        repeat (5) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        t_reset_gate();
        t_pin();
        edge_run(8'h00, 8'h01, 1, 0);
        edge_run(8'h04, 8'h01, 0, 1);
        edge_run(8'h08, 8'h01, 1, 1);
        edge_run(8'h0C, 8'h01, 1, 1);
        edge_run(8'h08, 8'h00, 0, 0);
        t_bypass();
        filt_run(8'h01, 1);
        filt_run(8'h02, 8);
        filt_run(8'h03, 32);
        wr(COF_ADDR_MODE, 8'h00);
        edge_run(8'h08, 8'h01, 0, 0);
        wr(COF_ADDR_GATE, 8'h00);
        cyc(2);
        rd_chk(COF_ADDR_OC, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
